// ### verilog/asrctl_host.sv
`timescale 1ns/1ps
module asrctl_host #(
	parameter int REC_CYCLES = asrctl_pkg::REC_PD_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// user request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [17:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [1:0] req_byte_en,
	input wire logic retention_exit,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	// memory pins
	output logic [17:0] word_address_lines,
	output logic select_active_low_n,
	output logic select_active_high,
	output logic lower_byte_strobe_n,
	output logic upper_byte_strobe_n,
	output logic write_strobe_n,
	output logic output_gate_n,
	input wire logic [15:0] shared_data_lines_in,
	output logic [15:0] shared_data_lines_out,
	output logic [15:0] shared_data_lines_oe
);
	// ************************************************************
	// sequencer state
	// ************************************************************
	typedef enum logic [2:0] {
		ST_WAKE, ST_IDLE, ST_RD_ACC, ST_RD_END,
		ST_WR_SET, ST_WR_PULSE, ST_WR_END, ST_GAP
	} asrctl_state_t;

	asrctl_state_t state_reg;
	logic [22:0] wake_reg;
	asrctl_cnt_if cnt ();

	asrctl_timer u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cnt(cnt)
	);

	// turns a byte enable into the two active-low lane strobes
	function automatic logic [1:0] lane_n(input logic [1:0] be);
		lane_n = ~be;
	endfunction

	// a request and a retention exit in one cycle: the exit wins
	logic start;
	assign start = (state_reg == ST_IDLE) && req_valid
		&& (req_byte_en != 2'h0) && !retention_exit;

	// ************************************************************
	// timer loads: one load on entry to ST_RD_ACC, ST_WR_SET and ST_GAP only
	// ************************************************************
	always_comb begin
		cnt.load = 1'b0;
		cnt.value = asrctl_pkg::CNT_ZERO;
		case (state_reg)
			ST_IDLE: begin
				if (start && !req_write) begin
					cnt.load = 1'b1; // full access wait
					cnt.value = 4'(asrctl_pkg::ACC_CYC);
				end else if (start) begin
					cnt.load = 1'b1; // strobe low for setup
					cnt.value = 4'(asrctl_pkg::WR_CYC);
				end
			end
			ST_RD_END, ST_WR_END: begin
				cnt.load = 1'b1; // float time before next cycle
				cnt.value = 4'(asrctl_pkg::DIS_CYC);
			end
			default: begin
				cnt.load = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_WAKE;
			wake_reg <= 23'h0;
		end else begin
			if (retention_exit) begin
				wake_reg <= 23'h0; // restart the recovery wait
				state_reg <= ST_WAKE;
			end else begin
				case (state_reg)
					ST_WAKE: begin
						if (32'(wake_reg) >= REC_CYCLES - 1) begin
							state_reg <= ST_IDLE;
						end else begin
							wake_reg <= wake_reg + 23'h1;
						end
					end
					ST_IDLE: begin
						if (start) begin
							state_reg <= req_write ? ST_WR_SET : ST_RD_ACC;
						end
					end
					ST_RD_ACC: begin
						if (cnt.done) begin
							state_reg <= ST_RD_END;
						end
					end
					ST_RD_END: state_reg <= ST_GAP;
					ST_WR_SET: state_reg <= ST_WR_PULSE;
					ST_WR_PULSE: begin
						if (cnt.done) begin
							state_reg <= ST_WR_END;
						end
					end
					ST_WR_END: state_reg <= ST_GAP;
					ST_GAP: begin
						if (cnt.done) begin
							state_reg <= ST_IDLE;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// memory pins: address, selects and strobes
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			word_address_lines <= 18'h0;
			select_active_low_n <= 1'b1;
			select_active_high <= 1'b0;
			lower_byte_strobe_n <= 1'b1;
			upper_byte_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
		end else if (retention_exit) begin
			// drop any access so the wake wait starts deselected
			select_active_low_n <= 1'b1;
			select_active_high <= 1'b0;
			lower_byte_strobe_n <= 1'b1;
			upper_byte_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
		end else if (start) begin
			// address and lanes latched once and held
			word_address_lines <= req_addr;
			select_active_low_n <= 1'b0;
			select_active_high <= 1'b1;
			{upper_byte_strobe_n, lower_byte_strobe_n} <=
				lane_n(req_byte_en);
			output_gate_n <= req_write; // gate only on reads
		end else begin
			case (state_reg)
				ST_WR_SET: write_strobe_n <= 1'b0;
				ST_WR_PULSE: begin
					if (cnt.done) begin
						write_strobe_n <= 1'b1; // selects stay till end
					end
				end
				ST_RD_ACC: begin
					if (cnt.done) begin
						output_gate_n <= 1'b1;
					end
				end
				ST_RD_END, ST_WR_END: begin
					// deselect; both lanes idle
					select_active_low_n <= 1'b1;
					select_active_high <= 1'b0;
					lower_byte_strobe_n <= 1'b1;
					upper_byte_strobe_n <= 1'b1;
				end
				default: begin
					output_gate_n <= output_gate_n;
				end
			endcase
		end
	end

	// ************************************************************
	// data bus drive: from strobe fall to one cycle after strobe rise
	// ************************************************************
	logic req_be_lo_reg;
	logic req_be_hi_reg;

	// write data and per-lane drive enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shared_data_lines_out <= 16'h0;
			shared_data_lines_oe <= 16'h0;
		end else if (retention_exit) begin
			shared_data_lines_oe <= 16'h0; // released with the strobes
		end else if (start && req_write) begin
			shared_data_lines_out <= req_wdata;
		end else if (state_reg == ST_WR_SET) begin
			// drive only with gate high and strobe going low
			shared_data_lines_oe <= {{8{req_be_hi_reg}}, {8{req_be_lo_reg}}};
		end else if (state_reg == ST_WR_END) begin
			shared_data_lines_oe <= 16'h0; // data held one cycle past strobe rise
		end
	end

	// lanes of the current request, kept for drive and read masking
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_be_lo_reg <= 1'b0;
			req_be_hi_reg <= 1'b0;
		end else if (start) begin
			req_be_lo_reg <= req_byte_en[0];
			req_be_hi_reg <= req_byte_en[1];
		end
	end

	// ************************************************************
	// user answer: sample after full access time
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0;
			req_ready <= 1'b0;
		end else begin
			rsp_valid <= (state_reg == ST_RD_ACC) && cnt.done;
			if ((state_reg == ST_RD_ACC) && cnt.done) begin
				// unused lanes read as zero; valid per
				rsp_rdata <= shared_data_lines_in &
					{{8{req_be_hi_reg}}, {8{req_be_lo_reg}}};
			end
			req_ready <= (state_reg == ST_GAP) && cnt.done
				&& !retention_exit;
		end
	end
endmodule

// ### verilog/asrctl_pkg.sv
package asrctl_pkg;

	// ************************************************************
	// geometry
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int WORDS = 262144;

	// ************************************************************
	// timing in ns (clock in ps, recovery in ms) and derived cycle counts at 40 MHz
	// ************************************************************
	localparam int CLK_PS = 25000;
	localparam int T_ACC_NS = 70;
	localparam int T_OE_ACC_NS = 35;
	localparam int T_DIS_NS = 25;
	localparam int T_WP_NS = 55;
	localparam int T_WSU_NS = 60;
	localparam int T_DSU_NS = 35;
	localparam int T_CYC_NS = 70;
	localparam int T_REC_PD_MS = 5;

	// least times round up
	localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int DIS_CYC = (T_DIS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WSU_CYC_A = (T_WSU_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WP_CYC_A = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC = (WSU_CYC_A > WP_CYC_A) ? WSU_CYC_A : WP_CYC_A;
	localparam int CYC_CYC = (T_CYC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam longint REC_PD_CYC_L =
		(64'(T_REC_PD_MS) * 64'h3B9ACA00 + 64'(CLK_PS) - 64'h1)
		/ 64'(CLK_PS);
	localparam int REC_PD_CYC = int'(REC_PD_CYC_L);

	localparam logic [3:0] CNT_ZERO = 4'h0;

	typedef enum logic [1:0] {
		ASRCTL_OP_NONE,
		ASRCTL_OP_READ,
		ASRCTL_OP_WRITE
	} asrctl_op_t;

endpackage

// ### verilog/asrctl_cnt_if.sv
`timescale 1ns/1ps
// counter load and done between the sequencer and its timer
interface asrctl_cnt_if;
	logic load;
	logic [3:0] value;
	logic done;
	modport ctl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface

// ### verilog/asrctl_timer.sv
`timescale 1ns/1ps
// down counter: done is high while the count sits at zero and no load is made
module asrctl_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// load and done
	asrctl_cnt_if.tmr cnt
);
	logic [3:0] count_reg;

	// reload on load, else count down to zero and hold
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= asrctl_pkg::CNT_ZERO;
		end else if (cnt.load) begin
			count_reg <= cnt.value;
		end else if (count_reg != asrctl_pkg::CNT_ZERO) begin
			count_reg <= count_reg - 4'h1;
		end
	end

	assign cnt.done = (count_reg == asrctl_pkg::CNT_ZERO) && !cnt.load;
endmodule

// ### verif/asrctl_sram_model.sv
`timescale 1ns/1ps
// ************************************************************
// behavioural static memory on the far side of the host
// ************************************************************
module asrctl_sram_model #(
	parameter int DLY_NS = 60
) (
	// control pins
	input wire logic [17:0] word_address_lines,
	input wire logic select_active_low_n,
	input wire logic select_active_high,
	input wire logic lower_byte_strobe_n,
	input wire logic upper_byte_strobe_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	// data lines
	input wire logic [15:0] shared_data_lines_in,
	output logic [15:0] mem_q,
	output logic [15:0] mem_oe
);
	logic [15:0] mem [262144];
	logic [15:0] last = 16'h0000;
	logic [15:0] rd;
	logic [15:0] lane;
	logic on;
	initial foreach (mem[i]) mem[i] = 16'h0000;
	// both selects pick the access; the lane strobes mask it per byte
	assign on = !select_active_low_n && select_active_high;
	assign lane = {{8{!upper_byte_strobe_n}},
		{8{!lower_byte_strobe_n}}};
	// drives only for a read, so write-first cycles stay floating;
	// turn-on is instant, the harshest case for a bus fight
	assign mem_oe = (on && write_strobe_n && !output_gate_n) ? lane
		: 16'h0000;
	// slow access, inertial so the old word outlives an address change;
	// a released lane shows the inverse of the last word
	assign #(DLY_NS) rd = mem[word_address_lines];
	assign mem_q = (mem_oe & rd) | (~mem_oe & ~last);
	always @(posedge output_gate_n) last <= rd;
	// store at the end of the overlap, per selected lane
	always @(posedge write_strobe_n) begin
		if (on)
			mem[word_address_lines] <= (mem[word_address_lines] & ~lane)
				| (shared_data_lines_in & lane);
	end
endmodule

// ### verif/asrctl_host_chk.sv
`timescale 1ns/1ps
// ************************************************************
// pin timing checks for the memory host
// ************************************************************
module asrctl_host_chk #(
	parameter int REC_CYCLES = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// status
	input wire logic retention_exit,
	input wire logic rsp_valid,
	// memory pins
	input wire logic [17:0] word_address_lines,
	input wire logic select_active_low_n,
	input wire logic select_active_high,
	input wire logic lower_byte_strobe_n,
	input wire logic upper_byte_strobe_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic [15:0] shared_data_lines_out,
	input wire logic [15:0] shared_data_lines_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// cycles since reset or retention exit, saturating
	int wake_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) wake_reg <= 0;
		else if (retention_exit) wake_reg <= 0;
		else if (wake_reg < REC_CYCLES) wake_reg <= wake_reg + 1;
	end
	chk_wake_quiet: assert property (
		wake_reg < REC_CYCLES |-> select_active_low_n && !select_active_high)
		else $error("access during recovery wait");
	chk_addr_hold: assert property (
		!write_strobe_n |=> $stable(word_address_lines))
		else $error("address moved during write");
	chk_addr_setup: assert property (
		$rose(write_strobe_n) |->
		$past(word_address_lines, 3) == word_address_lines)
		else $error("address setup to write end short");
	chk_sel_setup: assert property (
		$rose(write_strobe_n) |-> $past(select_active_low_n, 3) == 1'b0
		&& $past(select_active_high, 3)
		&& $past(lower_byte_strobe_n, 3) == lower_byte_strobe_n)
		else $error("select setup to write end short");
	chk_no_fight: assert property (
		!output_gate_n |-> shared_data_lines_oe == 16'h0000 && write_strobe_n)
		else $error("host drives while memory may drive");
	chk_pulse_width: assert property (
		$fell(write_strobe_n) |=> !write_strobe_n [*2])
		else $error("write pulse too short");
	chk_data_setup: assert property (
		$rose(write_strobe_n) |->
		$past(shared_data_lines_out, 2) == shared_data_lines_out)
		else $error("write data setup short");
	chk_gate_time: assert property (
		$fell(output_gate_n) |=> !output_gate_n [*2] ##[1:2] rsp_valid)
		else $error("read sampled before access time");
	cover property ($rose(rsp_valid));
	cover property ($rose(write_strobe_n));
	cover property (!upper_byte_strobe_n && lower_byte_strobe_n
		&& !output_gate_n);
endmodule

bind asrctl_host asrctl_host_chk #(.REC_CYCLES(REC_CYCLES)) u_chk (
	.clk_sys, .rst_n, .retention_exit, .rsp_valid, .word_address_lines,
	.select_active_low_n, .select_active_high, .lower_byte_strobe_n,
	.upper_byte_strobe_n, .write_strobe_n, .output_gate_n,
	.shared_data_lines_out, .shared_data_lines_oe);

// ### verif/asrctl_host_test.sv
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the memory host
// ************************************************************
module asrctl_host_test;
	localparam int REC = 8;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic retention_exit = 1'b0;
	logic [17:0] req_addr = 18'h00000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] req_byte_en = 2'h0;
	logic req_ready, rsp_valid, select_active_low_n, select_active_high;
	logic lower_byte_strobe_n, upper_byte_strobe_n, write_strobe_n;
	logic output_gate_n;
	logic [15:0] rsp_rdata, shared_data_lines_out, shared_data_lines_oe;
	logic [15:0] shared_data_lines_in, mem_q, q;
	logic [17:0] word_address_lines;
	int bad_count = 0;
	int comparisons = 0;
	// cycles from request to the first selected edge of the last transfer
	int wait_n = 0;
	always #12.5 clk_sys = ~clk_sys;
	// host drive wins a bit, otherwise the memory side shows
	assign shared_data_lines_in = (shared_data_lines_oe & shared_data_lines_out)
		| (~shared_data_lines_oe & mem_q);
	asrctl_host #(.REC_CYCLES(REC)) uut (.clk_sys, .rst_n, .req_valid,
		.req_write, .req_addr, .req_wdata, .req_byte_en, .retention_exit,
		.req_ready, .rsp_valid, .rsp_rdata, .word_address_lines,
		.select_active_low_n, .select_active_high, .lower_byte_strobe_n,
		.upper_byte_strobe_n, .write_strobe_n, .output_gate_n,
		.shared_data_lines_in, .shared_data_lines_out, .shared_data_lines_oe);
	asrctl_sram_model mem (.word_address_lines, .select_active_low_n,
		.select_active_high, .lower_byte_strobe_n, .upper_byte_strobe_n,
		.write_strobe_n, .output_gate_n, .shared_data_lines_in, .mem_q,
		.mem_oe());
	task automatic check(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// hold the request until selects show it taken, then wait for ready
	task automatic xfer(input logic w, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] be, output int n);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_byte_en <= be;
		wait_n = -1;
		for (n = 0; n < 60 && req_ready !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (select_active_low_n === 1'b0) req_valid <= 1'b0;
			if (select_active_low_n === 1'b0 && wait_n < 0) wait_n = n;
			if (rsp_valid === 1'b1) q = rsp_rdata;
		end
	endtask
	task automatic t_wake;
		int n;
		xfer(1'b0, 18'h3FFFF, 16'h0000, 2'h3, n);
		check("wake_read", q, 16'h0000);
		check("wake_wait", 16'(wait_n >= REC), 16'h0001);
		$display("test wake done");
	endtask
	task automatic t_rw;
		int n;
		xfer(1'b1, 18'h3FFFF, 16'hA5C3, 2'h3, n);
		xfer(1'b0, 18'h3FFFF, 16'h0000, 2'h3, n);
		check("top_word", q, 16'hA5C3);
		check("read_done", 16'(n < 60), 16'h0001);
		$display("test read write done");
	endtask
	task automatic t_lanes;
		int n;
		xfer(1'b1, 18'h00000, 16'hFFFF, 2'h3, n);
		xfer(1'b1, 18'h00000, 16'h1234, 2'h1, n);
		xfer(1'b0, 18'h00000, 16'h0000, 2'h3, n);
		check("lower_only", q, 16'hFF34);
		xfer(1'b1, 18'h00000, 16'h5600, 2'h2, n);
		xfer(1'b0, 18'h00000, 16'h0000, 2'h2, n);
		check("upper_only", q, 16'h5600);
		$display("test lanes done");
	endtask
	task automatic t_ignore;
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= 1'b1;
		req_byte_en <= 2'h0;
		repeat (12) begin
			@(posedge clk_sys);
			if (select_active_low_n !== 1'b1) n++;
		end
		req_valid <= 1'b0;
		check("no_lane_sel", 16'(n), 16'h0000);
		$display("test no lane done");
	endtask
	task automatic t_ret;
		int n;
		@(posedge clk_sys);
		retention_exit <= 1'b1;
		@(posedge clk_sys);
		retention_exit <= 1'b0;
		xfer(1'b0, 18'h00000, 16'h0000, 2'h3, n);
		check("ret_wait", 16'(wait_n >= REC), 16'h0001);
		check("ret_read", q, 16'h5634);
		$display("test retention done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_wake;
		t_rw;
		t_lanes;
		t_ignore;
		t_ret;
		results;
	end
	// watchdog: the whole run needs well under two hundred cycles
	initial begin
		#(25 * 3000);
		bad_count++;
		results;
	end
endmodule
